//--- hdl/ist_defs.svh
`ifndef IST_DEFS_SVH
`define IST_DEFS_SVH
// How it works
// - An instruction lasts the sum over all cycle kinds of its count times that kind's cost.
// - Cycles are fetch, branch read, stack, byte, word or internal; internal takes 1 state.
// - Fetch from on-chip program memory and byte access to on-chip data take 2 states each.
// - A branch address read for a memory-indirect call takes 2 states.
// - A stack cycle takes 2 states; a memory-indirect call runs 2 fetches, 1 read, 1 stack.
// - A peripheral byte access takes 2 or 3 states, chosen by which peripheral is addressed.
// - Non-memory add, add-with-extend, address add, AND, flag AND and bit ops run 1 fetch.
// - Memory bit tests: 2 fetches, 1 byte access; bit clear and set: 2 fetches, 2 bytes.
// - An 8-bit relative branch runs 2 fetches and nothing else, taken or not.

// State cost of each cycle kind
`define IST_ST_FETCH      2'd2
`define IST_ST_BRREAD     2'd2
`define IST_ST_STACK      2'd2
`define IST_ST_BYTE_MEM   2'd2
`define IST_ST_BYTE_FAST  2'd2
`define IST_ST_BYTE_SLOW  2'd3
`define IST_ST_WORD       2'd2
`define IST_ST_INTERNAL   2'd1
// Peripheral ids whose byte access needs the third state
`define IST_SLOW_PERIPH   16'hff00

// Cycle counts per operation class, 3-bit fields fetch/read/stack/byte/word/internal
`define IST_CNT_REG_ALU   18'h08000
`define IST_CNT_BIT_TEST  18'h10040
`define IST_CNT_BIT_RMW   18'h10080
`define IST_CNT_BRANCH    18'h10000
`define IST_CNT_CALL_IND  18'h11200
`define IST_CNT_ONE       3'h1
`define IST_CNT_ZERO      3'h0
`define IST_EL_ONE        6'h01
`endif

//--- hdl/ist_pkg.sv
package ist_pkg;
  typedef enum logic [2:0] {
    OP_REG_ALU  = 3'h0,
    OP_BIT_TEST = 3'h1,
    OP_BIT_RMW  = 3'h2,
    OP_BRANCH   = 3'h3,
    OP_CALL_IND = 3'h4
  } ist_op_t;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_FETCH    = 7'h02,
    ST_BRREAD   = 7'h04,
    ST_STACK    = 7'h08,
    ST_BYTE     = 7'h10,
    ST_WORD     = 7'h20,
    ST_INTERNAL = 7'h40
  } ist_state_t;

  typedef struct packed {
    logic [2:0] fetch;
    logic [2:0] brRead;
    logic [2:0] stack;
    logic [2:0] byteAcc;
    logic [2:0] wordAcc;
    logic [2:0] internal;
  } ist_cnt_t;

  typedef struct packed {
    ist_op_t    op;
    logic       periphSel;
    logic [3:0] periphId;
  } ist_req_t;
endpackage

//--- hdl/ist_timing.sv
`timescale 1ns/10ps
`include "ist_defs.svh"
module ist_timing import ist_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       reqValid,
  input  ist_req_t        reqIn,
  output logic            reqReady_q,
  output ist_state_t      state_q,
  output logic            cycleStart_q,
  output logic            instrDone_q,
  output logic [5:0]      instrStates_q
);

  ist_req_t   held_q;
  ist_cnt_t   rem_q;
  logic [1:0] stateLeft_q;
  logic [5:0] elapsed_q;
  logic [5:0] expect_q;
  ist_cnt_t   remDec;
  ist_state_t nxt;
  ist_cnt_t   accCnt;
  ist_state_t accKind;
  logic       accept;
  logic       cycleEnd;
  logic       finishing;

  function automatic ist_cnt_t opCounts(input ist_op_t op);
    case (op)
      OP_BIT_TEST: opCounts = ist_cnt_t'(`IST_CNT_BIT_TEST);
      OP_BIT_RMW:  opCounts = ist_cnt_t'(`IST_CNT_BIT_RMW);
      OP_BRANCH:   opCounts = ist_cnt_t'(`IST_CNT_BRANCH);
      OP_CALL_IND: opCounts = ist_cnt_t'(`IST_CNT_CALL_IND);
      default:     opCounts = ist_cnt_t'(`IST_CNT_REG_ALU);
    endcase
  endfunction

  // Fixed cycle order keeps peripheral stretching from reordering anything
  function automatic ist_state_t nextKind(input ist_cnt_t c);
    if (c.fetch != `IST_CNT_ZERO) nextKind = ST_FETCH;
    else if (c.brRead != `IST_CNT_ZERO) nextKind = ST_BRREAD;
    else if (c.stack != `IST_CNT_ZERO) nextKind = ST_STACK;
    else if (c.byteAcc != `IST_CNT_ZERO) nextKind = ST_BYTE;
    else if (c.wordAcc != `IST_CNT_ZERO) nextKind = ST_WORD;
    else if (c.internal != `IST_CNT_ZERO) nextKind = ST_INTERNAL;
    else nextKind = ST_IDLE;
  endfunction

  function automatic logic [1:0] stateCost(input ist_state_t k, input ist_req_t r);
    case (k)
      ST_FETCH:    stateCost = `IST_ST_FETCH;
      ST_BRREAD:   stateCost = `IST_ST_BRREAD;
      ST_STACK:    stateCost = `IST_ST_STACK;
      ST_BYTE: begin
        if (!r.periphSel) begin
          stateCost = `IST_ST_BYTE_MEM;
        end else if (((`IST_SLOW_PERIPH >> r.periphId) & 16'h0001) != 16'h0000) begin
          stateCost = `IST_ST_BYTE_SLOW;
        end else begin
          stateCost = `IST_ST_BYTE_FAST;
        end
      end
      ST_WORD:     stateCost = `IST_ST_WORD;
      ST_INTERNAL: stateCost = `IST_ST_INTERNAL;
      default:     stateCost = `IST_ST_INTERNAL;
    endcase
  endfunction

  // Total cost is the weighted sum of the cycle counts
  function automatic logic [5:0] totalCost(input ist_cnt_t c, input ist_req_t r);
    totalCost = 6'(c.fetch) * 6'(stateCost(ST_FETCH, r))
              + 6'(c.brRead) * 6'(stateCost(ST_BRREAD, r))
              + 6'(c.stack) * 6'(stateCost(ST_STACK, r))
              + 6'(c.byteAcc) * 6'(stateCost(ST_BYTE, r))
              + 6'(c.wordAcc) * 6'(stateCost(ST_WORD, r))
              + 6'(c.internal) * 6'(stateCost(ST_INTERNAL, r));
  endfunction

  always_comb begin
    accept    = reqValid && reqReady_q;
    accCnt    = opCounts(reqIn.op);
    accKind   = nextKind(accCnt);
    cycleEnd  = (state_q != ST_IDLE) && (stateLeft_q == 2'd0);
    remDec    = rem_q;
    case (state_q)
      ST_FETCH:    remDec.fetch    = rem_q.fetch - `IST_CNT_ONE;
      ST_BRREAD:   remDec.brRead   = rem_q.brRead - `IST_CNT_ONE;
      ST_STACK:    remDec.stack    = rem_q.stack - `IST_CNT_ONE;
      ST_BYTE:     remDec.byteAcc  = rem_q.byteAcc - `IST_CNT_ONE;
      ST_WORD:     remDec.wordAcc  = rem_q.wordAcc - `IST_CNT_ONE;
      ST_INTERNAL: remDec.internal = rem_q.internal - `IST_CNT_ONE;
      default:     remDec          = rem_q;
    endcase
    nxt       = nextKind(remDec);
    finishing = cycleEnd && (nxt == ST_IDLE);
  end

  // Cycle sequencer: hold each cycle for its full cost
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      rem_q       <= '0;
      stateLeft_q <= 2'd0;
      held_q      <= '0;
    end else if (accept) begin
      state_q     <= accKind;
      rem_q       <= accCnt;
      held_q      <= reqIn;
      stateLeft_q <= stateCost(accKind, reqIn) - 2'd1;
    end else if (cycleEnd) begin
      state_q     <= nxt;
      rem_q       <= remDec;
      stateLeft_q <= (nxt == ST_IDLE) ? 2'd0 : stateCost(nxt, held_q) - 2'd1;
    end else if (state_q != ST_IDLE) begin
      stateLeft_q <= stateLeft_q - 2'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reqReady_q   <= 1'b1;
      cycleStart_q <= 1'b0;
      instrDone_q  <= 1'b0;
    end else begin
      reqReady_q   <= accept ? 1'b0 : (finishing || reqReady_q);
      cycleStart_q <= accept || (cycleEnd && nxt != ST_IDLE);
      instrDone_q  <= finishing;
    end
  end

  // State counting; the result is only published at the end of the instruction
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      elapsed_q     <= 6'h00;
      expect_q      <= 6'h00;
      instrStates_q <= 6'h00;
    end else if (accept) begin
      elapsed_q <= `IST_EL_ONE;
      expect_q  <= totalCost(accCnt, reqIn);
    end else if (finishing) begin
      instrStates_q <= elapsed_q;
    end else if (state_q != ST_IDLE) begin
      elapsed_q <= elapsed_q + `IST_EL_ONE;
    end
  end

  property p_total;
    @(posedge clk_sys) disable iff (!rstn) instrDone_q |-> instrStates_q == expect_q;
  endproperty
  a_total: assert property (p_total) else $error("instruction state total wrong");

  // No op class issues internal cycles yet; this guards any class that address_add_op them
  property p_internal;
    @(posedge clk_sys) disable iff (!rstn)
      cycleStart_q && state_q == ST_INTERNAL |=> cycleStart_q || instrDone_q;
  endproperty
  a_internal: assert property (p_internal) else $error("internal cycle too long");

  property p_fetch;
    @(posedge clk_sys) disable iff (!rstn) cycleStart_q && state_q == ST_FETCH
      |=> !cycleStart_q && state_q == ST_FETCH ##1 (cycleStart_q || instrDone_q);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not 2 states");

  property p_brread;
    @(posedge clk_sys) disable iff (!rstn) cycleStart_q && state_q == ST_BRREAD
      |=> !cycleStart_q && state_q == ST_BRREAD;
  endproperty
  a_brread: assert property (p_brread) else $error("branch read not 2 states");

  property p_call;
    @(posedge clk_sys) disable iff (!rstn) accept && reqIn.op == OP_CALL_IND
      |=> state_q == ST_FETCH ##2 state_q == ST_FETCH ##2 state_q == ST_BRREAD
      ##2 state_q == ST_STACK ##2 instrDone_q;
  endproperty
  a_call: assert property (p_call) else $error("indirect call sequence wrong");

  property p_slow;
    @(posedge clk_sys) disable iff (!rstn)
      cycleStart_q && state_q == ST_BYTE && held_q.periphSel && held_q.periphId[3]
      |=> !cycleStart_q [*2] ##1 (cycleStart_q || instrDone_q);
  endproperty
  a_slow: assert property (p_slow) else $error("slow byte access not 3 states");

  property p_fast;
    @(posedge clk_sys) disable iff (!rstn)
      cycleStart_q && state_q == ST_BYTE && !(held_q.periphSel && held_q.periphId[3])
      |=> !cycleStart_q ##1 (cycleStart_q || instrDone_q);
  endproperty
  a_fast: assert property (p_fast) else $error("fast byte access not 2 states");

  property p_alu;
    @(posedge clk_sys) disable iff (!rstn) accept && reqIn.op == OP_REG_ALU |-> ##3 instrDone_q;
  endproperty
  a_alu: assert property (p_alu) else $error("single fetch op wrong length");

  property p_rmw;
    @(posedge clk_sys) disable iff (!rstn)
      accept && reqIn.op == OP_BIT_RMW && !reqIn.periphSel |-> ##9 instrDone_q;
  endproperty
  a_rmw: assert property (p_rmw) else $error("bit set or clear wrong length");

  property p_test;
    @(posedge clk_sys) disable iff (!rstn)
      accept && reqIn.op == OP_BIT_TEST && !reqIn.periphSel |-> ##7 instrDone_q;
  endproperty
  a_test: assert property (p_test) else $error("bit test wrong length");

  property p_branch;
    @(posedge clk_sys) disable iff (!rstn)
      accept && reqIn.op == OP_BRANCH |-> ##5 instrDone_q && instrStates_q == 6'h04;
  endproperty
  a_branch: assert property (p_branch) else $error("branch not 4 states");

  property p_order;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(state_q) && state_q != ST_IDLE |-> cycleStart_q;
  endproperty
  a_order: assert property (p_order) else $error("cycle changed mid-cost");

  // Ready must track idleness exactly, or a second instruction could overlap
  property p_ready;
    @(posedge clk_sys) disable iff (!rstn) reqReady_q == (state_q == ST_IDLE);
  endproperty
  a_ready: assert property (p_ready) else $error("ready out of step with idle");

  c_call:   cover property (@(posedge clk_sys) accept && reqIn.op == OP_CALL_IND);
  c_slow:   cover property (@(posedge clk_sys)
                            cycleStart_q && state_q == ST_BYTE && held_q.periphId[3]);
  c_b2b:    cover property (@(posedge clk_sys) instrDone_q && accept);
  c_rmw:    cover property (@(posedge clk_sys) accept && reqIn.op == OP_BIT_RMW && reqIn.periphSel);
  c_fast:   cover property (@(posedge clk_sys) cycleStart_q && state_q == ST_BYTE && !held_q.periphSel);
endmodule

//--- verif/ist_mem_model.sv
`timescale 1ns/10ps
module ist_mem_model import ist_pkg::*; (
  input  wire logic  clk_sys,
  input  wire logic  rstn,
  input  wire logic  clrCnt,
  input  ist_state_t state_q,
  output logic [6:0] fetchSt,
  output logic [6:0] brSt,
  output logic [6:0] stackSt,
  output logic [6:0] byteSt
);
  // Counts states spent on fetch, branch read, stack and byte accesses as memory and peripherals see them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fetchSt <= 7'h00;
      brSt    <= 7'h00;
      stackSt <= 7'h00;
      byteSt  <= 7'h00;
    end else if (clrCnt) begin
      fetchSt <= 7'h00;
      brSt    <= 7'h00;
      stackSt <= 7'h00;
      byteSt  <= 7'h00;
    end else begin
      if (state_q == ST_FETCH) fetchSt <= fetchSt + 7'h01;
      if (state_q == ST_BRREAD) brSt <= brSt + 7'h01;
      if (state_q == ST_STACK) stackSt <= stackSt + 7'h01;
      if (state_q == ST_BYTE) byteSt <= byteSt + 7'h01;
    end
  end
endmodule

//--- verif/ist_timing_tb_top.sv
`timescale 1ns/10ps
module ist_timing_tb_top import ist_pkg::*; ;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       reqValid = 1'b0;
  logic       clrCnt = 1'b0;
  ist_req_t   reqIn = '0;
  logic       reqReady_q, cycleStart_q, instrDone_q;
  ist_state_t state_q;
  logic [5:0] instrStates_q;
  logic [6:0] fetchSt, brSt, stackSt, byteSt;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;
  ist_timing i_ist_timing (.clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid),
    .reqIn(reqIn), .reqReady_q(reqReady_q), .state_q(state_q),
    .cycleStart_q(cycleStart_q), .instrDone_q(instrDone_q), .instrStates_q(instrStates_q));
  ist_mem_model i_ist_mem_model (.clk_sys(clk_sys), .rstn(rstn), .clrCnt(clrCnt),
    .state_q(state_q), .fetchSt(fetchSt), .brSt(brSt), .stackSt(stackSt), .byteSt(byteSt));
  always #5 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run is well under a thousand cycles, so this ceiling means a hang
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [6:0] e, input logic [6:0] g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Starts in a ready cycle, ends at the falling edge of the done cycle
  task automatic run_op(input ist_op_t op, input logic s, input logic [3:0] id,
                        input logic [6:0] e);
    int n;
    n = 0;
    reqIn = '{op: op, periphSel: s, periphId: id};
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    while (instrDone_q !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk_sys);
    end
    cmp("states", e, {1'b0, instrStates_q});
    cmp("latency", e, 7'(n));
  endtask
  task automatic t_reset();
    cmp("ready", 7'h01, {6'h00, reqReady_q});
    cmp("state", ST_IDLE, state_q);
    cmp("count", 7'h00, {1'b0, instrStates_q});
    $display("test reset done");
  endtask
  task automatic t_walk();
    reqIn = '{op: OP_BRANCH, periphSel: 1'b0, periphId: 4'h0};
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      cmp("walk", ST_FETCH, state_q);
      cmp("start", {6'h00, k[0]}, {6'h00, cycleStart_q});
      cmp("busy", 7'h00, {6'h00, reqReady_q});
      if (k == 3) reqValid = 1'b0;
      @(negedge clk_sys);
    end
    cmp("done", 7'h01, {6'h00, instrDone_q});
    cmp("ignored", 7'h04, {1'b0, instrStates_q});
    cmp("ready", 7'h01, {6'h00, reqReady_q});
    @(negedge clk_sys);
    cmp("idle", ST_IDLE, state_q);
    cmp("done pulse", 7'h00, {6'h00, instrDone_q});
    $display("test walk and refusal done");
  endtask
  task automatic t_classes();
    run_op(OP_REG_ALU, 1'b0, 4'h0, 7'h02);
    run_op(ist_op_t'(3'h5), 1'b0, 4'h0, 7'h02);
    run_op(ist_op_t'(3'h7), 1'b1, 4'hf, 7'h02);
    run_op(OP_BIT_TEST, 1'b0, 4'h9, 7'h06);
    run_op(OP_BIT_RMW, 1'b0, 4'h0, 7'h08);
    run_op(OP_BRANCH, 1'b0, 4'h0, 7'h04);
    $display("test classes back to back done");
  endtask
  task automatic t_periph();
    run_op(OP_BIT_TEST, 1'b1, 4'h7, 7'h06);
    run_op(OP_BIT_TEST, 1'b1, 4'h8, 7'h07);
    clrCnt = 1'b1;
    @(negedge clk_sys);
    clrCnt = 1'b0;
    run_op(OP_BIT_RMW, 1'b1, 4'hf, 7'h0a);
    cmp("byte states", 7'h06, byteSt);
    cmp("fetch states", 7'h04, fetchSt);
    $display("test peripheral done");
  endtask
  task automatic t_call();
    clrCnt = 1'b1;
    @(negedge clk_sys);
    clrCnt = 1'b0;
    run_op(OP_CALL_IND, 1'b0, 4'h0, 7'h08);
    cmp("fetch states", 7'h04, fetchSt);
    cmp("read states", 7'h02, brSt);
    cmp("stack states", 7'h02, stackSt);
    cmp("byte states", 7'h00, byteSt);
    $display("test indirect call done");
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_walk();
    t_classes();
    t_periph();
    t_call();
    close_out();
  end
endmodule
